// ==== rtl/wdt_consts.svh ====
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH

// Register byte offsets
`define WDT_OFF_CTRL 4'h0
`define WDT_OFF_COUNT 4'h4
`define WDT_OFF_STAT 4'h8

// Control field positions
`define WDT_CTRL_EN_BIT 0
`define WDT_CTRL_ACT_LSB 1
`define WDT_CTRL_ACT_MSB 2
`define WDT_CTRL_CAUSE_BIT 3

// Reset values
`define WDT_COUNT_RST 32'h0000_0000
`define WDT_ACT_RST 2'h3

// Reset pulse length in cycles
`define WDT_RST_PULSE 4'h8

// Bus answers
`define WDT_RESP_OKAY 2'h0
`define WDT_RESP_SLVERR 2'h2

`endif

// ==== rtl/wdt_pkg.sv ====
package wdt_pkg;
  // Expiry action codes
  typedef enum logic [1:0] {
    WDT_ACT_RESET = 2'h0,
    WDT_ACT_NMI = 2'h1,
    WDT_ACT_GPI = 2'h2,
    WDT_ACT_NONE = 2'h3
  } wdt_act_t;
endpackage

// ==== rtl/wdt_top.sv ====
// What this block does
// - The count lives in a 32-bit counter that software loads with a start value.
// - On expiry before a reload the chosen action fires: reset, NMI or interrupt.
// - Once enabled the counter runs down to zero and every reload restarts it.
// - A reset action resets both the core and all peripherals.
// - A control bit survives the reset and tells whether the watchdog caused it.
// - The counter decrements on the system clock only.
`timescale 1ns/1ps
`include "wdt_consts.svh"

module wdt_top
  import wdt_pkg::*;
(
  input wire logic clock, // System clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic [3:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [3:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read valid
  input wire logic s_axi_rready, // Read ready
  output logic core_rst, // Reset to core
  output logic periph_rst, // Reset to peripherals
  output logic nmi_pulse, // Nonmaskable interrupt pulse
  output logic gp_irq // General interrupt pulse
);

  logic [31:0] load_reg;
  logic [31:0] count_reg;
  logic en_reg;
  logic [1:0] act_reg;
  logic cause_reg;
  logic expired_reg;
  logic [3:0] rst_cnt_reg;
  logic nmi_reg;
  logic gpi_reg;
  logic [3:0] aw_reg;
  logic aw_have_reg;
  logic [31:0] w_reg;
  logic [3:0] ws_reg;
  logic w_have_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic wr_fire;
  logic reload;
  logic expire;
  logic [31:0] wr_merged;

  // Byte-lane merge of write data into an old word
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Write channel capture, either order
  assign s_axi_awready = !aw_have_reg && !bvalid_reg;
  assign s_axi_wready = !w_have_reg && !bvalid_reg;
  assign wr_fire = aw_have_reg && w_have_reg && !bvalid_reg;

  always_ff @(posedge clock) begin
    if (rst) begin
      aw_have_reg <= 1'b0;
      aw_reg <= 4'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_reg <= 1'b1;
      aw_reg <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_have_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      w_have_reg <= 1'b0;
      w_reg <= 32'h0000_0000;
      ws_reg <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_reg <= 1'b1;
      w_reg <= s_axi_wdata;
      ws_reg <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_have_reg <= 1'b0;
    end
  end

  // Write response
  always_ff @(posedge clock) begin
    if (rst) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `WDT_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= (aw_reg == `WDT_OFF_CTRL || aw_reg == `WDT_OFF_COUNT ||
                    aw_reg == `WDT_OFF_STAT) ? `WDT_RESP_OKAY : `WDT_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  // Control word as software would see it
  always_comb begin
    wr_merged = lane_merge({28'h0000_000, cause_reg, act_reg, en_reg}, w_reg, ws_reg);
  end

  // Reload on a count write, or on enable from disabled
  assign reload = wr_fire && ((aw_reg == `WDT_OFF_COUNT) ||
                  (aw_reg == `WDT_OFF_CTRL && wr_merged[`WDT_CTRL_EN_BIT] && !en_reg));

  always_ff @(posedge clock) begin
    if (rst) begin
      load_reg <= `WDT_COUNT_RST;
    end else if (wr_fire && aw_reg == `WDT_OFF_COUNT) begin
      load_reg <= lane_merge(load_reg, w_reg, ws_reg);
    end
  end

  // Enable and action fields; both follow every control write, even while the timer runs
  always_ff @(posedge clock) begin
    if (rst) begin
      en_reg <= 1'b0;
      act_reg <= `WDT_ACT_RST;
    end else if (wr_fire && aw_reg == `WDT_OFF_CTRL) begin
      en_reg <= wr_merged[`WDT_CTRL_EN_BIT];
      act_reg <= wr_merged[`WDT_CTRL_ACT_MSB:`WDT_CTRL_ACT_LSB];
    end
  end

  // countdown on system clock, reload restarts it
  always_ff @(posedge clock) begin
    if (rst) begin
      count_reg <= `WDT_COUNT_RST;
    end else if (reload) begin
      count_reg <= (wr_fire && aw_reg == `WDT_OFF_COUNT) ? lane_merge(load_reg, w_reg, ws_reg)
                                                         : load_reg;
    end else if (en_reg && count_reg != 32'h0000_0000) begin
      count_reg <= count_reg - 32'h0000_0001;
    end
  end

  assign expire = en_reg && !reload && !expired_reg && count_reg == 32'h0000_0000;

  always_ff @(posedge clock) begin
    if (rst) begin
      expired_reg <= 1'b0;
    end else if (reload || !en_reg) begin
      expired_reg <= 1'b0;
    end else if (expire) begin
      expired_reg <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      nmi_reg <= 1'b0;
      gpi_reg <= 1'b0;
    end else begin
      nmi_reg <= expire && act_reg == WDT_ACT_NMI;
      gpi_reg <= expire && act_reg == WDT_ACT_GPI;
    end
  end
  assign nmi_pulse = nmi_reg;
  assign gp_irq = gpi_reg;

  // reset pulse for core and peripherals
  always_ff @(posedge clock) begin
    if (rst) begin
      rst_cnt_reg <= 4'h0;
    end else if (expire && act_reg == WDT_ACT_RESET) begin
      rst_cnt_reg <= `WDT_RST_PULSE;
    end else if (rst_cnt_reg != 4'h0) begin
      rst_cnt_reg <= rst_cnt_reg - 4'h1;
    end
  end
  assign core_rst = rst_cnt_reg != 4'h0;
  assign periph_rst = rst_cnt_reg != 4'h0;

  // cause flag, not cleared by rst, set wins over clear
  always_ff @(posedge clock) begin
    if (expire && act_reg == WDT_ACT_RESET) begin
      cause_reg <= 1'b1;
    end else if (wr_fire && aw_reg == `WDT_OFF_STAT && ws_reg[0] && w_reg[0]) begin
      cause_reg <= 1'b0;
    end
  end

  // Read channel
  assign s_axi_arready = !rvalid_reg;

  always_ff @(posedge clock) begin
    if (rst) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `WDT_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= `WDT_RESP_OKAY;
      unique case (s_axi_araddr)
        `WDT_OFF_CTRL: rdata_reg <= {28'h0000_000, cause_reg === 1'b1, act_reg, en_reg};
        `WDT_OFF_COUNT: rdata_reg <= load_reg;
        `WDT_OFF_STAT: rdata_reg <= count_reg;
        default: begin
          rdata_reg <= 32'h0000_0000;
          rresp_reg <= `WDT_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

endmodule // wdt_top

// ==== bench/wdt_top_asserts.sv ====
`timescale 1ns/1ps
module wdt_chk (
  input logic clock, // Clock
  input logic rst, // Reset, active high
  input logic s_axi_bvalid, // Write response valid
  input logic s_axi_arvalid, // Read address valid
  input logic s_axi_arready, // Read address ready
  input logic s_axi_rvalid, // Read valid
  input logic [1:0] s_axi_bresp, // Write response
  input logic [1:0] s_axi_rresp, // Read response
  input logic [31:0] s_axi_rdata, // Read data
  input logic core_rst, // Core reset
  input logic periph_rst, // Peripheral reset
  input logic nmi_pulse, // Nonmaskable interrupt
  input logic gp_irq // General interrupt
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Eight cycles high, then low
  sequence s_rst_on;
    core_rst [*8] ##1 !core_rst;
  endsequence
  property p_rst_len; $rose(core_rst) |-> s_rst_on; endproperty
  property p_rst_pair; core_rst == periph_rst; endproperty
  property p_nmi_one; nmi_pulse |=> !nmi_pulse; endproperty
  property p_gp_one; gp_irq |=> !gp_irq; endproperty
  property p_act_excl; nmi_pulse |-> !gp_irq && !$rose(core_rst); endproperty
  property p_bresp; s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2; endproperty
  property p_err_data; s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0; endproperty
  property p_rd_next; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rst_len: assert property (p_rst_len)
    else $error("reset pulse length wrong");
  a_rst_pair: assert property (p_rst_pair)
    else $error("core and peripheral resets differ");
  a_nmi_one: assert property (p_nmi_one)
    else $error("nmi repeated");
  a_gp_one: assert property (p_gp_one)
    else $error("interrupt repeated");
  a_act_excl: assert property (p_act_excl)
    else $error("two actions at once");
  a_bresp: assert property (p_bresp)
    else $error("bad write response");
  a_err_data: assert property (p_err_data)
    else $error("error read carries data");
  a_rd_next: assert property (p_rd_next)
    else $error("read answer late");
endmodule // wdt_chk

bind wdt_top wdt_chk u_chk (.*);

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
`include "wdt_consts.svh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin mismatches++; \
  $display("[ERR] %0t got %h want %h", $time, a, e); end end
module tb_top import wdt_pkg::*; ;
  logic clock = 0, rst = 1, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, q = 0;
  logic awr, wrdy, bv, arr, rv, crst, prst, nmi, gp;
  logic [3:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rd, v, v2;
  logic [1:0] bresp, rresp, resp;
  int mismatches = 0, total_checks = 0, n_nmi = 0, n_gp = 0, n_rst = 0;
  always #2.5 clock = ~clock;
  wdt_top uut (.clock(clock), .rst(rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .core_rst(crst),
    .periph_rst(prst), .nmi_pulse(nmi), .gp_irq(gp));
  // Count expiry events, reset pulses by their rising edge
  always @(posedge clock) begin
    n_nmi <= n_nmi + nmi;
    n_gp <= n_gp + gp;
    n_rst <= n_rst + (crst && prst && !q);
    q <= crst;
  end
  task automatic put(input logic [3:0] a, input logic [31:0] d);
    logic ta, tw, tk;
    @(posedge clock);
    awa <= a;
    wd <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    br <= 1'h1;
    do begin
      @(negedge clock);
      ta = awv && awr;
      tw = wv && wrdy;
      tk = br && bv;
      if (tk) resp = bresp;
      @(posedge clock);
      if (ta) awv <= 1'h0;
      if (tw) wv <= 1'h0;
      if (tk) br <= 1'h0;
    end while (awv || wv || br);
  endtask
  task automatic get(input logic [3:0] a, output logic [31:0] d);
    logic ta, tk;
    @(posedge clock);
    ara <= a;
    arv <= 1'h1;
    rr <= 1'h1;
    do begin
      @(negedge clock);
      ta = arv && arr;
      tk = rr && rv;
      if (tk) d = rd;
      if (tk) resp = rresp;
      @(posedge clock);
      if (ta) arv <= 1'h0;
      if (tk) rr <= 1'h0;
    end while (arv || rr);
  endtask
  // Count first, then action, then enable
  task automatic run(input logic [1:0] act, input int w);
    put(`WDT_OFF_COUNT, 32'h14);
    put(`WDT_OFF_CTRL, {29'h0, act, 1'h0});
    put(`WDT_OFF_CTRL, {29'h0, act, 1'h1});
    repeat (w) @(posedge clock);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #20000;
    mismatches++;
    close_out;
  end
  initial begin
    repeat (2) @(posedge clock);
    rst <= 1'h0;
    get(`WDT_OFF_CTRL, v);
    `CHK(v[2:0], 3'h6)
    get(`WDT_OFF_COUNT, v);
    `CHK(v, `WDT_COUNT_RST)
    get(4'hC, v);
    `CHK(resp, `WDT_RESP_SLVERR)
    `CHK(v, 32'h0)
    put(4'hC, 32'h5);
    `CHK(resp, `WDT_RESP_SLVERR)
    $display("reset and map done");
    put(`WDT_OFF_COUNT, 32'hFFFF_FFF0);
    `CHK(resp, `WDT_RESP_OKAY)
    get(`WDT_OFF_COUNT, v);
    `CHK(v, 32'hFFFF_FFF0)
    put(`WDT_OFF_CTRL, 32'h7);
    get(`WDT_OFF_STAT, v);
    get(`WDT_OFF_STAT, v2);
    `CHK(v2 < v && v2[31:28] === 4'hF, 1'h1)
    $display("countdown done");
    run(WDT_ACT_NMI, 10);
    repeat (4) begin
      put(`WDT_OFF_COUNT, 32'h14);
      repeat (8) @(posedge clock);
    end
    `CHK(n_nmi, 0)
    repeat (60) @(posedge clock);
    `CHK(n_nmi, 1)
    run(WDT_ACT_GPI, 60);
    `CHK(n_gp, 1)
    `CHK(n_nmi, 1)
    run(WDT_ACT_RESET, 60);
    `CHK(n_rst, 1)
    $display("expiry actions done");
    rst <= 1'h1;
    repeat (2) @(posedge clock);
    rst <= 1'h0;
    get(`WDT_OFF_CTRL, v);
    `CHK(v[3:0], 4'hE)
    put(`WDT_OFF_STAT, 32'h1);
    get(`WDT_OFF_CTRL, v);
    `CHK(v[3], 1'h0)
    $display("cause bit done");
    close_out;
  end
endmodule // tb_top
